/* mbhp_host_port.v */
`timescale 1ns/100ps
`default_nettype none
`include "mbhp_map.vh"
module mbhp_host_port #(
    // Below 3 the read sample would beat the two bus sync flops
    parameter PHASE_CYCLES = `MBHP_PHASE_CYCLES
) (
    input wire clock, // 40 MHz system clock
    input wire resetn, // Asynchronous reset, active low
    input wire style_strobe, // User choice: 1 strobe mode, 0 enable mode
    input wire req, // Start an access when idle
    input wire req_write, // 1 write, 0 read
    input wire [7:0] req_addr, // Register address
    input wire [7:0] req_wdata, // Write data
    output wire req_ready, // High while idle and able to take req
    output reg done, // One-cycle pulse when access ends
    output reg [7:0] rdata, // Read data of last read
    output reg bus_style_select, // Style pin to device
    output reg chip_select_n, // Chip select, active low
    output reg address_strobe, // Address strobe, active high
    output reg data_strobe, // Data strobe or read enable
    output reg read_write, // Read/write level or write strobe
    input wire [7:0] muxed_addr_data_bus_in, // Bus level from pins
    output reg [7:0] muxed_addr_data_bus_out, // Bus drive value
    output reg muxed_addr_data_bus_oe // High while host drives bus
);
    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    // Two flops, so only rst_meta sees resetn rise close to a clock edge
    reg rst_meta;
    reg rst_n;
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ----------------------------------------
    // Bus input synchroniser
    // ----------------------------------------
    // Pins are asynchronous to this clock; only bus_sync is read
    reg [7:0] bus_meta;
    reg [7:0] bus_sync;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus_meta <= 8'h00;
            bus_sync <= 8'h00;
        end else begin
            bus_meta <= muxed_addr_data_bus_in;
            bus_sync <= bus_meta;
        end
    end

    // ----------------------------------------
    // Level helpers
    // ----------------------------------------
    // Data strobe rests low in strobe mode and high (inactive) in enable mode
    function ds_idle;
        input reg style;
        begin
            ds_idle = (style != `MBHP_STYLE_STROBE);
        end
    endfunction

    // Style decode shared by the start of an access and its data phase
    function is_strobe_style;
        input reg style;
        begin
            is_strobe_style = (style == `MBHP_STYLE_STROBE);
        end
    endfunction

    // ----------------------------------------
    // Sequencer state
    // ----------------------------------------
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ADDR = 3'h1;
    localparam [2:0] ST_HOLD = 3'h2;
    localparam [2:0] ST_DATA = 3'h3;
    localparam [2:0] ST_END = 3'h4;

    reg [2:0] state;
    // Direction is fixed for the whole access once req is taken
    reg is_write;
    wire tick;

    // ----------------------------------------
    // Write data capture
    // ----------------------------------------
    // The user need not hold write data after req is taken
    reg [7:0] req_wdata_q;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            req_wdata_q <= 8'h00;
        end else if (state == ST_IDLE && req) begin
            req_wdata_q <= req_wdata;
        end
    end

    // ----------------------------------------
    // Phase timer
    // ----------------------------------------
    // One shared timer: every phase of an access has the same length
    mbhp_phase_timer #(
        .CYCLES(PHASE_CYCLES)
    ) u_timer (
        .clock(clock),
        .rst_n(rst_n),
        .run(state != ST_IDLE),
        .tick(tick)
    );

    // ----------------------------------------
    // Request handshake
    // ----------------------------------------
    // No queue: a req that arrives while busy is simply not taken
    assign req_ready = (state == ST_IDLE);

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            // Pins rest deselected, strobes inactive, bus released
            state <= ST_IDLE;
            is_write <= 1'b0;
            done <= 1'b0;
            rdata <= 8'h00;
            bus_style_select <= `MBHP_STYLE_ENABLE;
            chip_select_n <= 1'b1;
            address_strobe <= 1'b0;
            data_strobe <= 1'b1;
            read_write <= 1'b1;
            muxed_addr_data_bus_out <= 8'h00;
            muxed_addr_data_bus_oe <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    // Style only changes between accesses, never mid-cycle
                    bus_style_select <= style_strobe;
                    // Idle data strobe: low in strobe mode, high (inactive) in enable mode
                    data_strobe <= ds_idle(style_strobe);
                    read_write <= 1'b1;
                    chip_select_n <= 1'b1;
                    address_strobe <= 1'b0;
                    muxed_addr_data_bus_oe <= 1'b0;
                    if (req) begin
                        is_write <= req_write;
                        // Every access opens with its own address strobe
                        address_strobe <= 1'b1;
                        chip_select_n <= 1'b0;
                        muxed_addr_data_bus_out <= req_addr;
                        muxed_addr_data_bus_oe <= 1'b1;
                        if (is_strobe_style(style_strobe)) begin
                            read_write <= !req_write;
                        end
                        state <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    if (tick) begin
                        // Falling strobe latches; address held one more phase
                        address_strobe <= 1'b0;
                        state <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (tick) begin
                        if (is_write) begin
                            muxed_addr_data_bus_out <= req_wdata_q;
                        end else begin
                            // Release lines so the device can answer
                            muxed_addr_data_bus_oe <= 1'b0;
                        end
                        // Enable write: data and strobe move together, latched on the rise
                        if (is_strobe_style(bus_style_select)) begin
                            data_strobe <= 1'b1;
                        end else if (is_write) begin
                            read_write <= 1'b0;
                        end else begin
                            data_strobe <= 1'b0;
                        end
                        state <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (tick) begin
                        // Bus value has settled through both sync flops by now
                        if (!is_write) begin
                            rdata <= bus_sync;
                        end
                        // Trailing strobe edge; write data stays on for hold
                        data_strobe <= ds_idle(bus_style_select);
                        read_write <= 1'b1;
                        state <= ST_END;
                    end
                end
                ST_END: begin
                    if (tick) begin
                        // Chip select drops only after both strobes are gone
                        chip_select_n <= 1'b1;
                        muxed_addr_data_bus_oe <= 1'b0;
                        done <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    // Unused codes fall back to idle with pins as they are
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // mbhp_host_port
`default_nettype wire

/* mbhp_map.vh */
`ifndef MBHP_MAP_VH
`define MBHP_MAP_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define MBHP_CLK_KHZ 40000
`define MBHP_PHASE_NS 150
`define MBHP_PHASE_CYCLES ((`MBHP_PHASE_NS * `MBHP_CLK_KHZ + 999999) / 1000000)

// ----------------------------------------
// Bus styles and bus width
// ----------------------------------------
`define MBHP_STYLE_STROBE 1'b1
`define MBHP_STYLE_ENABLE 1'b0
`define MBHP_BUS_WIDTH 8

`endif

/* mbhp_phase_timer.v */
`timescale 1ns/100ps
`default_nettype none
module mbhp_phase_timer #(
    parameter CYCLES = 6
) (
    input wire clock, // System clock
    input wire rst_n, // Synchronised reset, active low
    input wire run, // Count while high, clear when low
    output wire tick // One-cycle pulse at end of each phase
);
    reg [7:0] count;
    // Count is 8 bits wide, so CYCLES may not exceed 256
    localparam [31:0] LAST_FULL = CYCLES - 1;
    localparam [7:0] LAST = LAST_FULL[7:0];

    assign tick = run && (count == LAST);

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count <= 8'h00;
        end else if (!run || tick) begin
            count <= 8'h00;
        end else begin
            count <= count + 8'h01;
        end
    end
endmodule // mbhp_phase_timer
`default_nettype wire

/* mbhp_dev.sv */
`timescale 1ns/100ps
`default_nettype none
module mbhp_dev (
    input wire logic sty, // Style pin
    input wire logic sel_n, // Select, low
    input wire logic astb, // Addr strobe
    input wire logic dstb, // Data strobe
    input wire logic rw, // Read/write
    input wire logic pf, // Power fail
    input wire logic [7:0] bin, // Bus level
    output logic [7:0] dq, // Read data
    output logic doe // Drives bus
);
    logic [7:0] mem [0:255];
    logic [7:0] adr = 8'h00;
    logic ok = 1'b0;
    logic wl = 1'b0;
    logic pd = 1'b0;
    logic pr = 1'b1;
    wire logic sel = !sel_n && !pf;
    // One process owns the latched address and its valid flag
    always @(astb) begin
        if (astb) begin
            ok = 1'b0;
        end else begin
            adr = bin;
            ok = 1'b1;
        end
    end
    // One process owns the array; both write edges are found here
    always @(dstb or rw) begin
        // Level taken at the leading edge: the trailing edge races the rw restore
        if (!pd && dstb) wl = !rw;
        if (pd && !dstb && sty && sel && ok && wl) mem[adr] = bin;
        if (!pr && rw && !sty && sel && ok) mem[adr] = bin;
        pd = dstb;
        pr = rw;
    end
    assign dq = mem[adr];
    assign doe = sel && ok && rw && (sty ? dstb : !dstb);
endmodule // mbhp_dev
`default_nettype wire

/* mbhp_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module mbhp_monitor #(
    parameter int P = 6
) (
    input wire logic clock, // Clock
    input wire logic resetn, // Reset
    input wire logic bus_style_select, // Style
    input wire logic chip_select_n, // Select
    input wire logic address_strobe, // Addr strobe
    input wire logic data_strobe, // Data strobe
    input wire logic read_write, // Read/write
    input wire logic [7:0] muxed_addr_data_bus_out, // Bus out
    input wire logic muxed_addr_data_bus_oe // Bus enable
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    wire logic st = bus_style_select ? data_strobe : !(data_strobe && read_write);
    wire logic rd = read_write && (bus_style_select ? data_strobe : !data_strobe);
    property p_span; address_strobe || st |-> !chip_select_n; endproperty
    a_span: assert property (p_span) else $error("strobe unselected");
    property p_fight; !chip_select_n && rd |-> !muxed_addr_data_bus_oe; endproperty
    a_fight: assert property (p_fight) else $error("bus fight");
    property p_pulse; bus_style_select && $rose(data_strobe) |-> ##P $fell(data_strobe); endproperty
    a_pulse: assert property (p_pulse) else $error("strobe width");
    property p_rw; bus_style_select && data_strobe |-> $stable(read_write); endproperty
    a_rw: assert property (p_rw) else $error("rw moved");
    property p_enwr; !bus_style_select && $rose(read_write) && !chip_select_n
        |-> muxed_addr_data_bus_oe && $stable(muxed_addr_data_bus_out); endproperty
    a_enwr: assert property (p_enwr) else $error("write data");
    property p_stwr; bus_style_select && $fell(data_strobe) && !$past(read_write)
        |-> muxed_addr_data_bus_oe && $stable(muxed_addr_data_bus_out); endproperty
    a_stwr: assert property (p_stwr) else $error("write data");
    property p_sty; !chip_select_n && !$past(chip_select_n) |-> $stable(bus_style_select);
    endproperty
    a_sty: assert property (p_sty) else $error("style moved");
    property p_fresh; $fell(chip_select_n) |-> address_strobe; endproperty
    a_fresh: assert property (p_fresh) else $error("no addr strobe");
endmodule // mbhp_monitor
bind mbhp_host_port mbhp_monitor #(.P(PHASE_CYCLES)) u_mon (.clock, .resetn,
    .bus_style_select, .chip_select_n, .address_strobe, .data_strobe, .read_write,
    .muxed_addr_data_bus_out, .muxed_addr_data_bus_oe);
`default_nettype wire

/* muxed_byte_host_bus_port_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module muxed_byte_host_bus_port_tb_top;
    localparam int P = 4;
    logic clock = 1'b0, resetn = 1'b0, style_strobe = 1'b1, req = 1'b0;
    logic req_write = 1'b0, pf = 1'b0;
    logic [7:0] req_addr = 8'h00, req_wdata = 8'h00, last = 8'h00;
    wire logic req_ready, done, sty, sel_n, astb, dstb, rw, hoe, doe;
    wire logic [7:0] rdata, hout, dq;
    // Released bus shows a changing pattern, never a held value
    wire logic [7:0] bin = hoe ? hout : doe ? dq : ~last;
    int fails = 0, n_tests = 0;
    initial forever #12.5 clock = ~clock;
    always @(posedge clock) last <= bin;
    mbhp_host_port #(.PHASE_CYCLES(P)) u_dut (.clock, .resetn, .style_strobe, .req,
        .req_write, .req_addr, .req_wdata, .req_ready, .done, .rdata,
        .bus_style_select(sty), .chip_select_n(sel_n), .address_strobe(astb),
        .data_strobe(dstb), .read_write(rw), .muxed_addr_data_bus_in(bin),
        .muxed_addr_data_bus_out(hout), .muxed_addr_data_bus_oe(hoe));
    mbhp_dev u_dev (.sty, .sel_n, .astb, .dstb, .rw, .pf, .bin, .dq, .doe);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge clock) #1;
        check({7'h00, req_ready}, 8'h01);
        req = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        @(posedge clock) #1 req = 1'b0;
        check({7'h00, req_ready}, 8'h00);
        n = 0;
        while (done !== 1'b1 && n < 99) @(posedge clock) #1 n++;
        check(n[7:0], 8'(4 * P));
    endtask
    task automatic t_mode(input logic s);
        style_strobe = s;
        repeat (2) @(posedge clock);
        #1 check({7'h00, sty}, {7'h00, s});
        access(1'b1, 8'h20, {7'h28, s});
        access(1'b1, 8'hff, 8'h00);
        access(1'b0, 8'h20, 8'h00);
        check(rdata, {7'h28, s});
        access(1'b0, 8'hff, 8'h00);
        check(rdata, 8'h00);
        $display("test mode %0d done", s);
    endtask
    task automatic t_pf;
        pf = 1'b1;
        access(1'b1, 8'h20, 8'hee);
        pf = 1'b0;
        access(1'b0, 8'h20, 8'h00);
        check(rdata, 8'h50);
        $display("test power fail done");
    endtask
    task automatic end_sim;
        $display("checks %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // About 10 accesses of 18 cycles; limit leaves wide margin
    initial begin
        #20000;
        fails++;
        end_sim;
    end
    initial begin
        repeat (5) @(posedge clock);
        #1 resetn = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        t_mode(1'b1);
        t_mode(1'b0);
        t_pf;
        end_sim;
    end
endmodule // muxed_byte_host_bus_port_tb_top
`default_nettype wire
